// file: common/wsalu_pkg.sv
`default_nettype none
package wsalu_pkg;
   localparam int DATA_W = 8;
   localparam int WORD_W = 16;
   localparam int IMM_W  = 6;
   localparam int WORD_CYCLES = 2;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam int BIT_MSB_B = 7;
   localparam int BIT_MSB_W = 15;

   // Opcode select from the decoder
   typedef enum logic [1:0]
   {
      WSALU_OP_NONE = 2'h0,
      WSALU_OP_SUBW = 2'h1,
      WSALU_OP_ANDK = 2'h2,
      WSALU_OP_ORR  = 2'h3
   } wsalu_op_e;

   typedef enum logic [2:0]
   {
      WSALU_ST_IDLE = 3'h1,
      WSALU_ST_LOW  = 3'h2,
      WSALU_ST_HIGH = 3'h4
   } wsalu_st_e;

   typedef struct packed
   {
      logic s;
      logic v;
      logic n;
      logic z;
      logic c;
   } wsalu_flags_s;

   typedef struct packed
   {
      wsalu_op_e         op;
      logic [DATA_W-1:0] dest_val;
      logic [DATA_W-1:0] dest_hi_val;
      logic [DATA_W-1:0] source_register;
      logic [DATA_W-1:0] constant;
   } wsalu_req_s;

   typedef struct packed
   {
      logic              wr_lo;
      logic              wr_hi;
      logic [DATA_W-1:0] lo;
      logic [DATA_W-1:0] hi;
   } wsalu_res_s;

   localparam wsalu_flags_s FLAGS_RESET = 5'h00;
   localparam wsalu_res_s   RES_RESET   = 18'h00000;
endpackage
`default_nettype wire

// file: rtl/wsalu_core.sv
// Overview of operation
// - Word subtract treats register pair as 16 bits, writes difference back.
// - Word subtract takes two cycles, sets Z,C,N,V,S from 16-bit result.
// - AND with constant replaces destination, one cycle, sets Z,N,V,S.
// - AND second operand is the instruction constant, not a register.
// - Register OR replaces destination with OR of source, one cycle, Z,N,V,S.
`timescale 1ns/1ps
`default_nettype none
module wsalu_core
   import wsalu_pkg::*;
(
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   // Request from decoder
   input  wire logic         req_valid,
   input  wire wsalu_req_s   req,
   // Result to register file
   output var  wsalu_res_s   res,
   output var  wsalu_flags_s flags,
   output logic              busy,
   output logic              done
);
   wsalu_st_e         st_q;
   logic [WORD_W-1:0] diff_q;
   wsalu_flags_s      flags_d;
   wsalu_res_s        res_d;
   logic [DATA_W-1:0] byte_r;
   logic [WORD_W-1:0] diff_d;
   logic              take;

   assign take = clk_en && req_valid && (st_q == WSALU_ST_IDLE);

   assign diff_d = {req.dest_hi_val, req.dest_val}
                   - {{(WORD_W-DATA_W){1'b0}}, req.constant};

   always_comb
   begin
      byte_r = ZERO_BYTE;
      if (req.op == WSALU_OP_ANDK)
      begin
         byte_r = req.dest_val & req.constant;
      end
      else if (req.op == WSALU_OP_ORR)
      begin
         byte_r = req.dest_val | req.source_register;
      end
   end

   always_comb
   begin
      flags_d = flags;
      res_d   = RES_RESET;
      if (take && (req.op == WSALU_OP_ANDK || req.op == WSALU_OP_ORR))
      begin
         flags_d.z = (byte_r == ZERO_BYTE);
         flags_d.n = byte_r[BIT_MSB_B];
         flags_d.v = 1'b0;
         flags_d.s = byte_r[BIT_MSB_B];
         res_d.wr_lo = 1'b1;
         res_d.lo    = byte_r;
      end
      else if (st_q == WSALU_ST_LOW)
      begin
         flags_d.z = (diff_q == ZERO_WORD);
         flags_d.n = diff_q[BIT_MSB_W];
         // Borrow when the pair wraps below zero
         flags_d.c = ~res.hi[BIT_MSB_B] & diff_q[BIT_MSB_W];
         // Signed overflow: negative pair turned positive
         flags_d.v = res.hi[BIT_MSB_B] & ~diff_q[BIT_MSB_W];
         flags_d.s = diff_q[BIT_MSB_W]
                     ^ (res.hi[BIT_MSB_B] & ~diff_q[BIT_MSB_W]);
         res_d.wr_hi = 1'b1;
         res_d.lo    = diff_q[DATA_W-1:0];
         res_d.hi    = diff_q[WORD_W-1:DATA_W];
      end
      else if (take && req.op == WSALU_OP_SUBW)
      begin
         // Original high byte held for flag math
         res_d.wr_lo = 1'b1;
         res_d.lo    = diff_d[DATA_W-1:0];
         res_d.hi    = req.dest_hi_val;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q   <= WSALU_ST_IDLE;
         diff_q <= ZERO_WORD;
      end
      else if (clk_en)
      begin
         unique case (st_q)
            WSALU_ST_IDLE:
            begin
               if (take && req.op == WSALU_OP_SUBW)
               begin
                  st_q   <= WSALU_ST_LOW;
                  diff_q <= diff_d;
               end
            end
            WSALU_ST_LOW:
            begin
               st_q <= WSALU_ST_HIGH;
            end
            WSALU_ST_HIGH:
            begin
               st_q <= WSALU_ST_IDLE;
            end
            default:
            begin
               st_q <= WSALU_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         res   <= RES_RESET;
         flags <= FLAGS_RESET;
      end
      else if (clk_en)
      begin
         res   <= res_d;
         flags <= flags_d;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (clk_en)
      begin
         busy <= take && (req.op == WSALU_OP_SUBW);
         done <= (st_q == WSALU_ST_LOW)
                 || (take && (req.op == WSALU_OP_ANDK
                              || req.op == WSALU_OP_ORR));
      end
   end

   property p_subw_two;
      @(posedge clock) disable iff (!rst_n)
      (take && req.op == WSALU_OP_SUBW) ##1 clk_en |=> done && res.wr_hi;
   endproperty
   a_subw_two: assert property (p_subw_two)
      else $error("word subtract did not finish in two cycles");

   property p_and_one;
      @(posedge clock) disable iff (!rst_n)
      (take && req.op == WSALU_OP_ANDK)
      |=> done
          && res.lo == ($past(req.dest_val) & $past(req.constant));
   endproperty
   a_and_one: assert property (p_and_one)
      else $error("and with constant result wrong");

   property p_or_one;
      @(posedge clock) disable iff (!rst_n)
      (take && req.op == WSALU_OP_ORR)
      |=> res.lo == ($past(req.dest_val) | $past(req.source_register))
          && flags.v == 1'b0;
   endproperty
   a_or_one: assert property (p_or_one)
      else $error("register or result wrong");

   property p_sign;
      @(posedge clock) disable iff (!rst_n)
      done |-> flags.s == (flags.n ^ flags.v);
   endproperty
   a_sign: assert property (p_sign)
      else $error("sign flag not n xor v");

   property p_logic_keeps_c;
      @(posedge clock) disable iff (!rst_n)
      (take && req.op != WSALU_OP_SUBW) |=> flags.c == $past(flags.c);
   endproperty
   a_logic_keeps_c: assert property (p_logic_keeps_c)
      else $error("carry changed by logic op");

   property p_pair;
      @(posedge clock) disable iff (!rst_n)
      res.wr_hi |-> {res.hi, res.lo} == diff_q;
   endproperty
   a_pair: assert property (p_pair)
      else $error("pair result mismatch");

   property p_busy_word;
      @(posedge clock) disable iff (!rst_n)
      (take && req.op == WSALU_OP_SUBW)
      |=> busy && res.wr_lo && !res.wr_hi && !done;
   endproperty
   a_busy_word: assert property (p_busy_word)
      else $error("word subtract first cycle wrong");

   property p_and_flags;
      @(posedge clock) disable iff (!rst_n)
      (take && req.op == WSALU_OP_ANDK)
      |=> flags.z == (res.lo == ZERO_BYTE)
          && flags.n == res.lo[BIT_MSB_B] && !flags.v;
   endproperty
   a_and_flags: assert property (p_and_flags)
      else $error("and with constant flags wrong");

   property p_or_flags;
      @(posedge clock) disable iff (!rst_n)
      (take && req.op == WSALU_OP_ORR)
      |=> flags.z == (res.lo == ZERO_BYTE)
          && flags.n == res.lo[BIT_MSB_B];
   endproperty
   a_or_flags: assert property (p_or_flags)
      else $error("register or flags wrong");

   property p_frozen;
      @(posedge clock) disable iff (!rst_n)
      !clk_en |=> $stable(flags) && $stable(res) && $stable(st_q);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// file: tb/wsalu_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module wsalu_regfile
   import wsalu_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Writes from the datapath
   input  wire wsalu_res_s res,
   // Stored bytes
   output logic [7:0]      lo_q,
   output logic [7:0]      hi_q
);
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lo_q <= ZERO_BYTE;
         hi_q <= ZERO_BYTE;
      end
      else
      begin
         if (res.wr_lo)
            lo_q <= res.lo;
         if (res.wr_hi)
            hi_q <= res.hi;
      end
   end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) num_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("ERROR %s exp %h got %h", nm, e, a); end
module tb;
   import wsalu_pkg::*;
   logic         clock = 1'b0;
   logic         rst_n = 1'b0;
   logic         clk_en = 1'b1;
   logic         req_valid = 1'b0;
   wsalu_req_s   req = '0;
   wsalu_res_s   res;
   wsalu_flags_s flags;
   wsalu_flags_s ef = FLAGS_RESET;
   logic         busy;
   logic         done;
   logic [7:0]   lo_q;
   logic [7:0]   hi_q;
   int           n_fail = 0;
   int           num_checks = 0;
   always #12.5 clock = ~clock;
   wsalu_core i_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .req_valid(req_valid), .req(req), .res(res), .flags(flags),
      .busy(busy), .done(done));
   wsalu_regfile i_rf (.clock(clock), .rst_n(rst_n), .res(res),
      .lo_q(lo_q), .hi_q(hi_q));
   task automatic run(input wsalu_op_e op, input logic [7:0] d, h, s, k);
      logic [15:0] p;
      logic [15:0] r;
      int          n;
      p = {h, d};
      r = (op == WSALU_OP_SUBW) ? p - k
        : {h, (op == WSALU_OP_ANDK) ? d & k : d | s};
      if (op == WSALU_OP_SUBW)
      begin
         ef = '{s: r[15] ^ (p[15] & ~r[15]), v: p[15] & ~r[15],
                n: r[15], z: r == ZERO_WORD, c: p < k};
      end
      else
      begin
         ef = '{s: r[7], v: 1'b0, n: r[7], z: r[7:0] == ZERO_BYTE, c: ef.c};
      end
      @(posedge clock);
      req_valid <= 1'b1;
      req <= '{op: op, dest_val: d, dest_hi_val: h, source_register: s,
               constant: k};
      @(posedge clock);
      req_valid <= 1'b0;
      n = 1;
      #1;
      `CHK("busy", op == WSALU_OP_SUBW, busy)
      while (done !== 1'b1 && n < 8)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      `CHK("latency", (op == WSALU_OP_SUBW) ? WORD_CYCLES : 1, n)
      `CHK("flags", ef, flags)
      `CHK("result low", r[7:0], res.lo)
      if (op == WSALU_OP_SUBW)
      begin
         `CHK("result high", r[15:8], res.hi)
      end
      // Register file takes the write one edge later
      @(posedge clock);
      #1;
      `CHK("low byte", r[7:0], lo_q)
      if (op == WSALU_OP_SUBW)
      begin
         `CHK("high byte", r[15:8], hi_q)
      end
   endtask
   task automatic t_freeze;
      // word subtract stalls while clock enable is low
      ef = FLAGS_RESET;
      @(posedge clock);
      req_valid <= 1'b1;
      req <= '{op: WSALU_OP_SUBW, dest_val: 8'h10, dest_hi_val: 8'h00,
               source_register: 8'h00, constant: 8'h01};
      @(posedge clock);
      req_valid <= 1'b0;
      clk_en <= 1'b0;
      repeat (3) @(posedge clock);
      clk_en <= 1'b1;
      #1;
      `CHK("frozen busy", 1'b1, busy)
      `CHK("frozen done", 1'b0, done)
      @(posedge clock);
      #1;
      `CHK("thawed done", 1'b1, done)
      `CHK("thawed flags", ef, flags)
      `CHK("thawed high", 8'h00, res.hi)
      `CHK("thawed low", 8'h0F, res.lo)
   endtask
   task automatic t_reset;
      // flags and stored bytes cleared by a reset after a word subtract ends
      run(WSALU_OP_SUBW, 8'h00, 8'h00, 8'h00, 8'h01);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      `CHK("mid reset flags", FLAGS_RESET, flags)
      `CHK("mid reset low", 8'h00, lo_q)
      `CHK("mid reset high", 8'h00, hi_q)
      ef = FLAGS_RESET;
      run(WSALU_OP_ORR, 8'h00, 8'h00, 8'h80, 8'h00);
   endtask
   task automatic t_logic;
      run(WSALU_OP_ANDK, 8'hF0, 8'h12, 8'hFF, 8'h3C);
      run(WSALU_OP_ANDK, 8'h0F, 8'h00, 8'hFF, 8'h30);
      run(WSALU_OP_ORR, 8'h81, 8'h00, 8'h02, 8'h3F);
      run(WSALU_OP_ORR, 8'h00, 8'h00, 8'h00, 8'h3F);
   endtask
   task automatic t_word;
      // borrow, then carry kept by a logic op
      run(WSALU_OP_SUBW, 8'h00, 8'h00, 8'h00, 8'h01);
      run(WSALU_OP_ANDK, 8'hFF, 8'h00, 8'h00, 8'h01);
      run(WSALU_OP_SUBW, 8'h00, 8'h80, 8'h00, 8'h3F);
      run(WSALU_OP_SUBW, 8'h05, 8'h00, 8'h00, 8'h05);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #(25 * 2000);
      n_fail++;
      stop_test();
   end
   initial
   begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      `CHK("reset flags", FLAGS_RESET, flags)
      t_logic();
      t_word();
      t_freeze();
      t_reset();
      stop_test();
   end
endmodule
`default_nettype wire
